// file: rtl/fault_supervisor_defs.svh
/*
  Timing counts and limits for the fault supervisor.
  Assumes a 50 MHz system clock; included by its bare name.
*/
`ifndef FAULT_SUPERVISOR_DEFS_SVH
`define FAULT_SUPERVISOR_DEFS_SVH

`define CLK_PERIOD_NS      20
`define RETRY_MS           20
`define RETRY_CYCLES       ((`RETRY_MS * 1000000) / `CLK_PERIOD_NS)
`define NVM_RETRY_LIMIT    3
`define FREQ_ARM_HALVES    20
`define DG_DEFAULT         16
`define SETTLE_DEFAULT     64
`define STAGE_DEFAULT      8
`define POWER_ON_DEFAULT   256
`define PHASE_MIN_DEFAULT  4
`define INRANGE_WIN_DEFAULT 64
`define INRANGE_CROSS_MAX  4

`endif

// file: rtl/fault_supervisor_pkg.sv
/*
  Types shared by the fault supervisor files.
  Assumes nothing of its surroundings.
*/
package fault_supervisor_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'b000,
    ST_DIAG     = 3'b001,
    ST_NORMAL   = 3'b010,
    ST_FAULT    = 3'b011,
    ST_DISABLED = 3'b100
  } sup_state_e;

endpackage : fault_supervisor_pkg

// file: rtl/deglitch_if.sv
/*
  Carries raw conditions into the deglitch bank and filtered flags back.
  Assumes one clock domain.
*/
`timescale 1ns/10ps
interface deglitch_if #(parameter int N = 16);
  logic [N-1:0] raw;
  logic [N-1:0] clr;
  logic [N-1:0] flag;
  modport bank (input raw, input clr, output flag);
  modport user (output raw, output clr, input flag);
endinterface : deglitch_if

// file: rtl/deglitch_bank.sv
/*
  Bank of persistence counters, one per fault condition.
  Assumes conditions are synchronous to clk_sys.
*/
`timescale 1ns/10ps
module deglitch_bank #(
  parameter int N  = 16,
  parameter int DG = 16
)(
  // System
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  // Conditions
  deglitch_if.bank    dg
);
  localparam int CW = $clog2(DG + 1);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ch
      logic [CW-1:0] cnt_q;
      logic          flag_q;
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          cnt_q  <= '0;
          flag_q <= 1'b0;
        end
        else if (dg.clr[i] || !dg.raw[i])
        begin
          // Any break in the condition restarts the count
          cnt_q  <= '0;
          flag_q <= 1'b0;
        end
        else if (cnt_q == CW'(DG - 1))
          flag_q <= 1'b1;
        else
          cnt_q <= cnt_q + CW'(1);
      end
      assign dg.flag[i] = flag_q;

      persist_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(flag_q) |-> $past(dg.raw[i], 1) && $past(dg.raw[i], 2))
        else $error("flag rose without persistent condition");
    end
  endgenerate
endmodule : deglitch_bank

// file: rtl/fault_supervisor_diagnostics.sv
/*
  Fault supervisor: state sequencing, initialization checks and run time
  fault routing for an inductive position sensor front end.
  Assumes analog comparators and self-test engines deliver synchronous
  levels and pulses; all inputs are synchronous to clk_sys.
*/
// What this block does
// - Watch both supply rails in diag, normal, fault, disabled; shut down on undervoltage.
// - After supply recovery go idle and rerun power-on sequence.
// - Configuration CRC mismatch during power-up diagnostics disables the device.
// - Logic or monitor self-test failure during diagnostics disables the device.
// - Sensor pin and gain-select pin tests at power-up; failure disables.
// - Regulator capacitor check only in 5 V mode, at power-up, not from fault.
// - Enable resonator, await its amplitude/common-mode fault clearing, then stage front end, gain, outputs.
// - Hold all checks but supply, overvoltage and overtemperature cleared for a settling interval before monitoring.
// - Normal only after power-on time, no faults; auto gain needs target met.
// - Supply undervoltage monitored only in 5 V mode, deglitched, cleared as soon as it drops.
// - Supply, regulator overvoltage, undervoltage, overtemperature go to fault until clear.
// - Signal path faults go to fault, then retry diagnostics.
// - Compare output and internal zero-crossing states when rotation is valid.
// - Output short flagged after deglitch; outputs stay driven meanwhile.
// - Exactly one sine crossing between cosine crossings, and vice versa.
// - Arm frequency imbalance after rotation in range for 20 half cycles.
// - Flag phase imbalance if crossing-to-crossing delay below minimum.
// - Auto gain: gain code at either limit is an input range fault, deglitched.
// - Input pins repeated crossings or persistent excursion, then further deglitch.
// - Same range test on low-pass outputs with own thresholds, same dwell.
// - Safety register CRC mismatch disables the device, checked while monitoring.
// - Critical register copy mismatch disables the device at once.
// - Retry diagnostics from disabled after 20 ms; CRC failure retries three times.
// - Fault state keeps resonator, front end off and outputs tri-stated.
`timescale 1ns/10ps
`include "fault_supervisor_defs.svh"
module fault_supervisor_diagnostics
  import fault_supervisor_pkg::*;
#(
  parameter int RETRY_CYC = `RETRY_CYCLES,
  parameter int DG        = `DG_DEFAULT,
  parameter int SETTLE    = `SETTLE_DEFAULT,
  parameter int STAGE     = `STAGE_DEFAULT,
  parameter int POWER_ON  = `POWER_ON_DEFAULT,
  parameter int PHASE_MIN = `PHASE_MIN_DEFAULT,
  parameter int WIN       = `INRANGE_WIN_DEFAULT
)(
  // System
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Supply and mode
  input  wire logic       regulated_supply_rail_uv,
  input  wire logic       core_supply_rail_uv,
  input  wire logic       mode_5v,
  input  wire logic       gain_auto,
  input  wire logic       vcc_ov,
  input  wire logic       vcc_uv,
  input  wire logic       vcc_uv_recovered,
  input  wire logic       reg_ov,
  input  wire logic       over_temp,
  // Self tests
  input  wire logic       nvm_crc_done,
  input  wire logic       nvm_crc_ok,
  input  wire logic       logic_self_test_done,
  input  wire logic       logic_self_test_fail,
  input  wire logic       analog_self_test_fail,
  input  wire logic       sensor_pin_test_fail,
  input  wire logic       gain_select_test_fail,
  input  wire logic       reg_cap_loss,
  // Resonator and signal path
  input  wire logic       resonator_amp_cm_fault,
  input  wire logic       resonator_freq_fault,
  input  wire logic       out_range_fault,
  input  wire logic       out_cm_fault,
  input  wire logic       out_diff_mismatch,
  input  wire logic [1:0] out_zc,
  input  wire logic [1:0] gain_zc,
  input  wire logic       rot_valid,
  input  wire logic       rot_1k_seen,
  input  wire logic       rot_below_10k,
  input  wire logic       gain_loop_target,
  input  wire logic       gain_at_limit,
  input  wire logic       in_above,
  input  wire logic       in_below,
  input  wire logic       lpf_above,
  input  wire logic       lpf_below,
  // Register integrity and straps
  input  wire logic       reg_crc_ok,
  input  wire logic       reg_copy_match,
  input  wire logic       test_mode_strap,
  input  wire logic       test_output_strap,
  input  wire logic       gain_select_pin,
  // Controls
  output logic            resonator_en,
  output logic            front_end_en,
  output logic            gain_en,
  output logic            out_drive_en,
  output logic [2:0]      state_out
);
  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam int TW = 16;
  localparam int NC = 16;
  // Deglitch channel indices
  localparam int C_VOV = 0, C_VUV = 1, C_ROV = 2, C_OT = 3, C_RFQ = 4, C_RAC = 5;
  localparam int C_ORG = 6, C_OCM = 7, C_OSH = 8, C_GLM = 9, C_INP = 10, C_LPF = 11;
  localparam int C_ZC = 12, C_GSP = 13, C_INC = 14, C_LPC = 15;

  sup_state_e    st_q;
  logic [TW-1:0] tmr_q;
  logic [RW-1:0] rty_q;
  logic [1:0]    nvm_fail_q;
  logic          nvm_last_q;
  logic          from_fault_q;
  logic [2:0]    step_q;
  logic          mon_q;
  logic          strap_tm_q, strap_to_q, strap_gs_q;
  logic [1:0]    sin_cnt_q, cos_cnt_q;
  logic [1:0]    zc_q;
  logic [4:0]    arm_q;
  logic          freq_imb_q, phase_imb_q;
  logic [TW-1:0] ph_q;
  logic [TW-1:0] win_q;
  logic [2:0]    inx_q, lpx_q;
  logic          in_dc_q, lp_dc_q;
  logic          supply_uv;
  logic          init_fail, recov_hit, retry_hit, disable_hit;

  deglitch_if #(.N(NC)) dg ();
  deglitch_bank #(.N(NC), .DG(DG)) u_dg (.clk_sys(clk_sys), .nrst(nrst), .dg(dg));

  assign supply_uv = regulated_supply_rail_uv || core_supply_rail_uv;

  // Raw conditions; all but the supply, regulator overvoltage and temperature channels are held clear while settling
  always_comb
  begin
    dg.raw        = '0;
    dg.raw[C_VOV] = vcc_ov;
    dg.raw[C_VUV] = mode_5v && vcc_uv;
    dg.raw[C_ROV] = reg_ov;
    dg.raw[C_OT]  = over_temp;
    dg.raw[C_RFQ] = resonator_freq_fault;
    dg.raw[C_RAC] = resonator_amp_cm_fault;
    dg.raw[C_ORG] = out_range_fault;
    dg.raw[C_OCM] = out_cm_fault;
    dg.raw[C_OSH] = out_diff_mismatch;
    dg.raw[C_GLM] = gain_auto && gain_at_limit;
    dg.raw[C_INP] = in_above || in_below;
    dg.raw[C_LPF] = lpf_above || lpf_below;
    dg.raw[C_ZC]  = rot_valid && (out_zc != gain_zc);
    dg.raw[C_GSP] = mon_q && (gain_select_pin != strap_gs_q);
    dg.raw[C_INC] = in_dc_q;
    dg.raw[C_LPC] = lp_dc_q;
    dg.clr        = {NC{!mon_q}};
    // Undervoltage flag clears in 5 V mode as soon as vcc_uv drops, recovery level or not, and always outside it
    dg.clr[C_VUV] = !mode_5v || (vcc_uv_recovered && !vcc_uv);
    dg.clr[C_VOV] = 1'b0;
    dg.clr[C_ROV] = 1'b0;
    dg.clr[C_OT]  = 1'b0;
  end

  logic forcing, retry_flt;
  assign forcing   = dg.flag[C_VOV] || dg.flag[C_VUV] || dg.flag[C_ROV] || dg.flag[C_OT];
  assign retry_flt = dg.flag[C_RFQ] || dg.flag[C_RAC] || dg.flag[C_ORG] || dg.flag[C_OCM]
                   || dg.flag[C_OSH] || dg.flag[C_ZC] || freq_imb_q || phase_imb_q
                   || dg.flag[C_GLM] || dg.flag[C_INC] || dg.flag[C_LPC];
  assign disable_hit = mon_q && (!reg_crc_ok || !reg_copy_match
                     || test_mode_strap != strap_tm_q || test_output_strap != strap_to_q
                     || dg.flag[C_GSP]);
  assign init_fail = (nvm_crc_done && !nvm_crc_ok)
                   || (logic_self_test_done && (logic_self_test_fail || analog_self_test_fail))
                   || sensor_pin_test_fail || gain_select_test_fail
                   || (mode_5v && !from_fault_q && reg_cap_loss);
  assign retry_hit = (rty_q == RW'(RETRY_CYC - 1));
  assign recov_hit = nvm_last_q && (nvm_fail_q == 2'(`NVM_RETRY_LIMIT));

  // Main sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q         <= ST_IDLE;
      step_q       <= 3'h0;
      tmr_q        <= '0;
      from_fault_q <= 1'b0;
      nvm_last_q   <= 1'b0;
    end
    else if (supply_uv && st_q != ST_IDLE)
    begin
      st_q   <= ST_IDLE;
      step_q <= 3'h0;
      tmr_q  <= '0;
      from_fault_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_q + TW'(1);
      case (st_q)
        ST_IDLE:
          if (!supply_uv)
          begin
            st_q  <= ST_DIAG;
            tmr_q <= '0;
          end
        ST_DIAG:
          if (init_fail || disable_hit)
          begin
            st_q       <= ST_DISABLED;
            nvm_last_q <= nvm_crc_done && !nvm_crc_ok;
          end
          else if (forcing || retry_flt)
            st_q <= ST_FAULT;
          else
            case (step_q)
              3'h0:
                if (nvm_crc_done && logic_self_test_done)
                begin
                  step_q <= 3'h1;
                  tmr_q  <= '0;
                end
              3'h1:
                if (!resonator_amp_cm_fault)
                begin
                  step_q <= 3'h2;
                  tmr_q  <= '0;
                end
                else if (tmr_q == TW'(DG))
                  st_q <= ST_FAULT;
              3'h2, 3'h3, 3'h4:
                if (tmr_q == TW'(STAGE))
                begin
                  step_q <= step_q + 3'h1;
                  tmr_q  <= '0;
                end
              3'h5:
                if (tmr_q == TW'(SETTLE))
                begin
                  step_q <= 3'h6;
                  tmr_q  <= '0;
                end
              default:
                if (tmr_q >= TW'(POWER_ON))
                begin
                  if (gain_auto && !gain_loop_target)
                    st_q <= ST_DISABLED;
                  else
                    st_q <= ST_NORMAL;
                end
            endcase
        ST_NORMAL:
          if (disable_hit)
            st_q <= ST_DISABLED;
          else if (forcing || retry_flt)
            st_q <= ST_FAULT;
        ST_FAULT:
          if (disable_hit)
            st_q <= ST_DISABLED;
          else if (!forcing)
          begin
            st_q         <= ST_DIAG;
            step_q       <= 3'h0;
            from_fault_q <= 1'b1;
            tmr_q        <= '0;
          end
        ST_DISABLED:
          if (retry_hit && !recov_hit)
          begin
            st_q   <= ST_DIAG;
            step_q <= 3'h0;
            tmr_q  <= '0;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Retry timer and configuration CRC failure count
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rty_q      <= '0;
      nvm_fail_q <= 2'h0;
    end
    else
    begin
      if (st_q == ST_DISABLED && !retry_hit)
        rty_q <= rty_q + RW'(1);
      else
        rty_q <= '0;
      // Counts retries taken after a configuration check failure
      if (st_q == ST_DISABLED && retry_hit && nvm_last_q && !recov_hit)
        nvm_fail_q <= nvm_fail_q + 2'h1;
    end
  end

  // Monitoring enable and strap capture
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mon_q      <= 1'b0;
      strap_tm_q <= 1'b0;
      strap_to_q <= 1'b0;
      strap_gs_q <= 1'b0;
    end
    else
    begin
      mon_q <= (st_q == ST_NORMAL) || (st_q == ST_FAULT)
            || (st_q == ST_DIAG && step_q == 3'h6);
      if (st_q == ST_DIAG && step_q == 3'h0)
      begin
        strap_tm_q <= test_mode_strap;
        strap_to_q <= test_output_strap;
        strap_gs_q <= gain_select_pin;
      end
    end
  end

  // Zero-crossing order, arming and phase spacing
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      zc_q <= 2'h0;
      sin_cnt_q <= 2'h0;
      cos_cnt_q <= 2'h0;
      arm_q <= 5'h0;
      freq_imb_q <= 1'b0;
      phase_imb_q <= 1'b0;
      ph_q <= '0;
    end
    else
    begin
      zc_q <= gain_zc;
      if (!mon_q)
      begin
        sin_cnt_q <= 2'h0;
        cos_cnt_q <= 2'h0;
        arm_q <= 5'h0;
        freq_imb_q <= 1'b0;
        phase_imb_q <= 1'b0;
      end
      else
      begin
        if (!(rot_1k_seen && rot_below_10k))
          arm_q <= 5'h0;
        else if ((zc_q[0] != gain_zc[0]) && arm_q != 5'(`FREQ_ARM_HALVES))
          arm_q <= arm_q + 5'h1;
        if (zc_q[0] != gain_zc[0])
        begin
          if (arm_q == 5'(`FREQ_ARM_HALVES) && cos_cnt_q != 2'h1)
            freq_imb_q <= 1'b1;
          cos_cnt_q <= 2'h0;
          sin_cnt_q <= (sin_cnt_q == 2'h3) ? 2'h3 : sin_cnt_q + 2'h1;
        end
        if (zc_q[1] != gain_zc[1])
        begin
          if (arm_q == 5'(`FREQ_ARM_HALVES) && sin_cnt_q != 2'h1)
            freq_imb_q <= 1'b1;
          sin_cnt_q <= 2'h0;
          cos_cnt_q <= (cos_cnt_q == 2'h3) ? 2'h3 : cos_cnt_q + 2'h1;
        end
        if ((zc_q ^ gain_zc) != 2'h0)
        begin
          if (rot_valid && ph_q < TW'(PHASE_MIN) && (zc_q ^ gain_zc) != 2'h3)
            phase_imb_q <= 1'b1;
        end
      end
      ph_q <= ((zc_q ^ gain_zc) != 2'h0) ? '0 : ph_q + ((ph_q == '1) ? TW'(0) : TW'(1));
    end
  end

  // Input and filter range: repeated crossings in a window or dwell
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      win_q <= '0;
      inx_q <= 3'h0;
      lpx_q <= 3'h0;
      in_dc_q <= 1'b0;
      lp_dc_q <= 1'b0;
    end
    else
    begin
      win_q <= (win_q == TW'(WIN)) ? '0 : win_q + TW'(1);
      if (win_q == TW'(WIN) || !mon_q)
      begin
        inx_q <= 3'h0;
        lpx_q <= 3'h0;
      end
      else
      begin
        if ($rose(in_above || in_below) && inx_q != 3'h7)
          inx_q <= inx_q + 3'h1;
        if ($rose(lpf_above || lpf_below) && lpx_q != 3'h7)
          lpx_q <= lpx_q + 3'h1;
      end
      in_dc_q <= dg.flag[C_INP] || inx_q >= 3'(`INRANGE_CROSS_MAX);
      lp_dc_q <= dg.flag[C_LPF] || lpx_q >= 3'(`INRANGE_CROSS_MAX);
    end
  end

  // Output enables follow state and stage
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      resonator_en <= 1'b0;
      front_end_en <= 1'b0;
      gain_en      <= 1'b0;
      out_drive_en <= 1'b0;
      state_out    <= 3'h0;
    end
    else
    begin
      resonator_en <= !supply_uv && (st_q == ST_NORMAL || (st_q == ST_DIAG && step_q >= 3'h1));
      front_end_en <= !supply_uv && (st_q == ST_NORMAL || (st_q == ST_DIAG && step_q >= 3'h3));
      gain_en      <= !supply_uv && (st_q == ST_NORMAL || (st_q == ST_DIAG && step_q >= 3'h4));
      out_drive_en <= !supply_uv && (st_q == ST_NORMAL);
      state_out    <= st_q;
    end
  end

  safe_outputs_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_FAULT) |=> !out_drive_en && !resonator_en)
    else $error("outputs active in fault state");
  uv_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    supply_uv |=> st_q == ST_IDLE ##1 !out_drive_en)
    else $error("undervoltage did not shut down");
  crc_disable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_DIAG && nvm_crc_done && !nvm_crc_ok && !supply_uv) |=> st_q == ST_DISABLED)
    else $error("config crc failure not disabling");
  copy_disable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_NORMAL && mon_q && !reg_copy_match && !supply_uv) |=> st_q == ST_DISABLED)
    else $error("register copy mismatch ignored");
  retry_limit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_DISABLED && recov_hit) |=> st_q != ST_DIAG)
    else $error("retried past limit");
  retry_time_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_DISABLED && $past(st_q) == ST_DISABLED && !supply_uv && !retry_hit)
      |=> st_q != ST_DIAG)
    else $error("early retry from disabled");
  forcing_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q == ST_FAULT && forcing && !disable_hit && !supply_uv) |=> st_q == ST_FAULT)
    else $error("left fault while forcing fault");
  settle_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!mon_q && !$past(mon_q)) |-> !freq_imb_q && !phase_imb_q)
    else $error("fault flags set while settling");
  auto_target_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($rose(st_q == ST_NORMAL)) |-> $past(!gain_auto || gain_loop_target))
    else $error("normal entered off gain target");
endmodule : fault_supervisor_diagnostics

// file: verification/mcu_sampler.sv
/*
  Far-side model: a controller input sampling one analog output pin.
  Assumes a pull-up resistor takes the pin whenever the output stage releases it.
*/
`timescale 1ns/10ps
module mcu_sampler #(
  parameter logic [7:0] PULL_LEVEL = 8'hFF
)(
  // System
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Output stage
  input  wire logic out_drive_en,
  // Verdict
  output logic      fault_seen
);
  logic [7:0] code_q;
  logic [7:0] pin_level;

  // Driven signal sweeps a legal band; released pin sits at the pull level
  assign pin_level = out_drive_en ? (8'h40 + {1'b0, code_q[6:0]}) : PULL_LEVEL;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      code_q     <= 8'h00;
      fault_seen <= 1'b1;
    end
    else
    begin
      code_q     <= code_q + 8'h01;
      fault_seen <= (pin_level > 8'hEF) || (pin_level < 8'h10);
    end
  end
endmodule : mcu_sampler

// file: verification/tb_top.sv
/*
  Self-checking bench for the fault supervisor and its sampling partner.
  Assumes shortened counts set through the supervisor's parameters.
*/
`timescale 1ns/10ps
module tb_top import fault_supervisor_pkg::*;;
  localparam int DG_T    = 4;
  localparam int RETRY_T = 50;

  typedef struct packed { logic [3:0] src; logic [2:0] exp; } row_s;

  logic       clk_sys = 1'b0;
  logic       nrst, mode_5v, gain_auto, vcc_ov, vcc_uv, vcc_uv_recovered, reg_ov, over_temp;
  logic       regulated_supply_rail_uv, core_supply_rail_uv, nvm_crc_done, nvm_crc_ok;
  logic       logic_self_test_done, logic_self_test_fail, analog_self_test_fail;
  logic       sensor_pin_test_fail, gain_select_test_fail, reg_cap_loss;
  logic       resonator_amp_cm_fault, resonator_freq_fault, out_range_fault, out_cm_fault;
  logic       out_diff_mismatch, rot_valid, rot_1k_seen, rot_below_10k, gain_loop_target;
  logic       gain_at_limit, in_above, in_below, lpf_above, lpf_below, reg_crc_ok;
  logic       reg_copy_match, test_mode_strap, test_output_strap, gain_select_pin;
  logic [1:0] out_zc, gain_zc;
  logic       resonator_en, front_end_en, gain_en, out_drive_en, fault_seen;
  logic [2:0] state_out;
  int         fail_count, compares, retries;
  logic [2:0] prev;
  row_s       rows [12] = '{
    '{4'h0, ST_FAULT}, '{4'h1, ST_FAULT}, '{4'h2, ST_FAULT}, '{4'h3, ST_FAULT},
    '{4'h4, ST_FAULT}, '{4'hA, ST_FAULT}, '{4'hB, ST_FAULT}, '{4'h5, ST_DISABLED},
    '{4'h6, ST_DISABLED}, '{4'h7, ST_DISABLED}, '{4'h8, ST_DISABLED},
    '{4'h9, ST_DISABLED}};

  always #10 clk_sys = ~clk_sys;

  fault_supervisor_diagnostics #(.RETRY_CYC(RETRY_T), .DG(DG_T), .SETTLE(4), .STAGE(2),
    .POWER_ON(60), .PHASE_MIN(4), .WIN(64)) uut (.clk_sys, .nrst,
    .regulated_supply_rail_uv, .core_supply_rail_uv, .mode_5v, .gain_auto, .vcc_ov, .vcc_uv,
    .vcc_uv_recovered, .reg_ov, .over_temp, .nvm_crc_done, .nvm_crc_ok, .logic_self_test_done,
    .logic_self_test_fail, .analog_self_test_fail, .sensor_pin_test_fail,
    .gain_select_test_fail, .reg_cap_loss, .resonator_amp_cm_fault, .resonator_freq_fault,
    .out_range_fault, .out_cm_fault, .out_diff_mismatch, .out_zc, .gain_zc, .rot_valid,
    .rot_1k_seen, .rot_below_10k, .gain_loop_target, .gain_at_limit, .in_above, .in_below,
    .lpf_above, .lpf_below, .reg_crc_ok, .reg_copy_match, .test_mode_strap,
    .test_output_strap, .gain_select_pin, .resonator_en, .front_end_en, .gain_en,
    .out_drive_en, .state_out);

  mcu_sampler partner (.clk_sys, .nrst, .out_drive_en, .fault_seen);

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk_state(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t state got %h exp %h", $time, got, exp);
    end
  endtask : chk_state

  task automatic chk_bits(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t enables got %h exp %h", $time, got, exp);
    end
  endtask : chk_bits

  task automatic wait_state(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (state_out !== exp && n < lim)
    begin
      tick(1);
      n++;
    end
    chk_state(state_out, exp);
  endtask : wait_state

  task automatic set_src(input logic [3:0] idx, input logic on);
    case (idx)
      4'h0: vcc_ov = on;
      4'h1: reg_ov = on;
      4'h2: over_temp = on;
      4'h3: resonator_freq_fault = on;
      4'h4: out_cm_fault = on;
      4'h5: reg_crc_ok = !on;
      4'h6: reg_copy_match = !on;
      4'h7: test_mode_strap = on;
      4'h8: test_output_strap = on;
      4'h9: gain_select_pin = on;
      4'hB: {rot_valid, out_zc} = {on, 1'b0, on};
      default:
      begin
        vcc_uv = on;
        vcc_uv_recovered = !on;
      end
    endcase
  endtask : set_src

  // Holds reset with every input at a healthy level
  task automatic reset_dut();
    nrst = 1'b0;
    {regulated_supply_rail_uv, core_supply_rail_uv, gain_auto, vcc_ov, vcc_uv, reg_ov} = '0;
    {over_temp, logic_self_test_fail, analog_self_test_fail, sensor_pin_test_fail} = '0;
    {gain_select_test_fail, reg_cap_loss, resonator_amp_cm_fault, resonator_freq_fault} = '0;
    {out_range_fault, out_cm_fault, out_diff_mismatch, rot_valid, rot_1k_seen} = '0;
    {rot_below_10k, gain_at_limit, in_above, in_below, lpf_above, lpf_below} = '0;
    {test_mode_strap, test_output_strap, gain_select_pin, out_zc, gain_zc} = '0;
    {mode_5v, vcc_uv_recovered, nvm_crc_done, nvm_crc_ok, logic_self_test_done} = '1;
    {gain_loop_target, reg_crc_ok, reg_copy_match} = '1;
    tick(12);
  endtask : reset_dut

  task automatic to_normal();
    reset_dut();
    nrst = 1'b1;
    wait_state(ST_NORMAL, 400);
  endtask : to_normal

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  initial
  begin
    fail_count = 0;
    compares = 0;
    reset_dut();
    chk_state(state_out, ST_IDLE);
    chk_bits({resonator_en, front_end_en, gain_en, out_drive_en, 1'b0}, 5'b00000);
    nrst = 1'b1;
    wait_state(ST_NORMAL, 400);
    tick(3);
    chk_bits({resonator_en, front_end_en, gain_en, out_drive_en, fault_seen}, 5'b11110);
    foreach (rows[i])
    begin
      to_normal();
      set_src(rows[i].src, 1'b1);
      wait_state(rows[i].exp, 40);
      tick(3);
      chk_bits({resonator_en, front_end_en, gain_en, out_drive_en, fault_seen}, 5'b00001);
    end
    // Undervoltage ignored outside 5 V mode
    to_normal();
    mode_5v = 1'b0;
    set_src(4'hA, 1'b1);
    tick(20);
    chk_state(state_out, ST_NORMAL);
    // Balanced crossings after arming, then a doubled sine crossing
    to_normal();
    {rot_valid, rot_1k_seen, rot_below_10k} = 3'b111;
    repeat (21)
    begin
      {out_zc, gain_zc} = {2{gain_zc ^ 2'b01}};
      tick(8);
      {out_zc, gain_zc} = {2{gain_zc ^ 2'b10}};
      tick(8);
    end
    chk_state(state_out, ST_NORMAL);
    {out_zc, gain_zc} = {2{gain_zc ^ 2'b01}};
    tick(8);
    {out_zc, gain_zc} = {2{gain_zc ^ 2'b01}};
    wait_state(ST_FAULT, 10);
    // Crossings two cycles apart
    to_normal();
    rot_valid = 1'b1;
    {out_zc, gain_zc} = 4'h5;
    tick(2);
    {out_zc, gain_zc} = 4'hF;
    wait_state(ST_FAULT, 10);
    // Short glitch must not trip, a held one must
    to_normal();
    set_src(4'h0, 1'b1);
    tick(DG_T - 2);
    set_src(4'h0, 1'b0);
    tick(10);
    chk_state(state_out, ST_NORMAL);
    set_src(4'h0, 1'b1);
    wait_state(ST_FAULT, 40);
    tick(30);
    chk_state(state_out, ST_FAULT);
    set_src(4'h0, 1'b0);
    wait_state(ST_DIAG, 40);
    // Rail undervoltage, then recovery through idle
    to_normal();
    regulated_supply_rail_uv = 1'b1;
    wait_state(ST_IDLE, 5);
    tick(3);
    chk_bits({resonator_en, front_end_en, gain_en, out_drive_en, fault_seen}, 5'b00001);
    regulated_supply_rail_uv = 1'b0;
    wait_state(ST_DIAG, 10);
    to_normal();
    core_supply_rail_uv = 1'b1;
    wait_state(ST_IDLE, 5);
    // Automatic gain: normal on target, gain code at a limit faults
    reset_dut();
    gain_auto = 1'b1;
    nrst = 1'b1;
    wait_state(ST_NORMAL, 400);
    gain_at_limit = 1'b1;
    wait_state(ST_FAULT, 40);
    // Self-test failures and a missed auto gain target disable
    reset_dut();
    logic_self_test_fail = 1'b1;
    nrst = 1'b1;
    wait_state(ST_DISABLED, 40);
    reset_dut();
    sensor_pin_test_fail = 1'b1;
    nrst = 1'b1;
    wait_state(ST_DISABLED, 40);
    reset_dut();
    reg_cap_loss = 1'b1;
    nrst = 1'b1;
    wait_state(ST_DISABLED, 40);
    reset_dut();
    {gain_auto, gain_loop_target} = 2'b10;
    nrst = 1'b1;
    wait_state(ST_DISABLED, 400);
    // Configuration check failure: timed retry, then a stop
    reset_dut();
    nvm_crc_ok = 1'b0;
    nrst = 1'b1;
    wait_state(ST_DISABLED, 40);
    tick(RETRY_T - 10);
    chk_state(state_out, ST_DISABLED);
    wait_state(ST_DIAG, 20);
    retries = 1;
    prev = state_out;
    repeat (400)
    begin
      tick(1);
      if (state_out === ST_DIAG && prev !== ST_DIAG)
        retries++;
      prev = state_out;
    end
    chk_bits(5'(retries), 5'h03);
    chk_state(state_out, ST_DISABLED);
    tick(200);
    chk_state(state_out, ST_DISABLED);
    close_out();
  end

  initial
  begin
    #(20 * 20000);
    fail_count++;
    $display("Error t=%0t watchdog expired %h %h", $time, state_out, 3'h0);
    close_out();
  end
endmodule : tb_top
